// ==== bus_timeout.sv ====
// Stuck-bus timer in the system clock domain
module bus_timeout import tws_pkg::*; #(
  parameter int unsigned LIMIT_P = TIMEOUT_CYC
) (
  input wire logic clk_i, // System clock
  input wire logic srst_i, // Synchronous reset, active high
  input wire logic low_i, // Line low inside a frame, link domain
  output logic tmo_tgl_o // Toggles once per expiry
);
  logic low_s;
  logic [TMO_W-1:0] cnt_r;
  logic fired_r;
  logic hit;

  sync2 #(.W(1)) u_low_sync (
    .clk_i(clk_i),
    .d_i(low_i),
    .q_o(low_s)
  );

  assign hit = !fired_r && cnt_r == TMO_W'(LIMIT_P - 1);

  // Counter restarts on every release, so only one unbroken low
  // period can expire
  always_ff @(posedge clk_i) begin
    if (srst_i || !low_s) begin
      cnt_r <= '0;
    end else if (!fired_r) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // One expiry per low period; a fresh low period re-arms it
  always_ff @(posedge clk_i) begin
    if (srst_i || !low_s) begin
      fired_r <= 1'b0;
    end else if (hit) begin
      fired_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tmo_tgl_o <= 1'b0;
    end else if (low_s && hit) begin
      tmo_tgl_o <= ~tmo_tgl_o;
    end
  end
endmodule

// ==== sync2.sv ====
// Two-flop synchroniser for levels entering a clock domain
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i, // Destination clock
  input wire logic [W-1:0] d_i, // Levels from another domain
  output logic [W-1:0] q_o // Synchronised levels
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    meta_r <= d_i;
  end

  always_ff @(posedge clk_i) begin
    q_o <= meta_r;
  end
endmodule

// ==== tws_master_model.sv ====
// Behavioural two-wire bus master that drives the slave port
module tws_master_model (
  input wire logic clk_i, // Timing reference
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Clock line, only this master drives it
  output logic sda_o // 0 pulls data low, 1 releases to pull-up
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Phases of 100 ns keep SCL far above 1 kHz, slave needs >= 75 ns
  task automatic hp();
    repeat (10) @(posedge clk_i);
    #1;
  endtask
  // Data set while SCL low and held through the whole high phase
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    hp();
    scl_o = 1'b1;
    hp();
    r = sda_i;
    scl_o = 1'b0;
    hp();
  endtask
  task automatic start();
    sda_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b1;
    hp();
  endtask
  task automatic wbyte(input logic [7:0] v, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, nak);
  endtask
  // drv lets the bench imitate a rival responder pulling bits low
  task automatic rbyte(input logic [7:0] drv, input logic ack,
                       output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(drv[i], v[i]);
    end
    bit_io(~ack, r);
  endtask
endmodule

// ==== tws_pkg.sv ====
// Shared constants and types for the two-wire sensor slave port
package tws_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_MS = 54;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int TMO_W = 23;
  localparam logic [3:0] ADDR_HI = 4'h9;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] ARA_ADDR = 8'h19;
  localparam logic [4:0] HS_CODE = 5'h01;
  localparam logic [7:0] GC_CMD_LATCH = 8'h04;
  localparam logic [7:0] GC_CMD_RESET = 8'h06;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_TLOW = 2'h2;
  localparam logic [1:0] PTR_THIGH = 2'h3;
  localparam logic [1:0] PTR_RST = 2'h0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] TLOW_RST = 16'h4b00;
  localparam logic [15:0] THIGH_RST = 16'h5000;
  localparam int CFG_MODE_BIT = 1;
  localparam logic [1:0] BIDX_PTR = 2'h0;
  localparam logic [1:0] BIDX_HI = 2'h1;
  localparam logic [1:0] BIDX_LO = 2'h2;
  localparam logic [1:0] BIDX_MAX = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_MACK
  } state_t;
endpackage

// ==== tws_slave.sv ====
// Two-wire slave port of a temperature sensor, with alert and timeout
module tws_slave import tws_pkg::*; #(
  parameter int unsigned TIMEOUT_CYC_P = TIMEOUT_CYC
) (
  input wire logic CLK_I, // System clock, 100 MHz
  input wire logic SRST_I, // Synchronous reset, active high
  input wire logic LINK_CLK_I, // Free-running link sampling clock
  input wire logic SCL_I, // Serial clock pin level
  output logic SCL_O, // Serial clock drive value
  output logic SCL_OE_O, // Serial clock drive enable, never set
  input wire logic SDA_I, // Serial data pin level
  output logic SDA_O, // Serial data drive value, always low
  output logic SDA_OE_O, // High while pulling data low
  input wire logic ADDR_SELECT_PIN_0_I, // Address select pin 0
  input wire logic ADDR_SELECT_PIN_1_I, // Address select pin 1
  input wire logic ADDR_SELECT_PIN_2_I, // Address select pin 2
  input wire logic [15:0] TEMP_I, // Temperature word, link domain
  input wire logic ALERT_SET_I, // Limit comparator alert request
  input wire logic ALERT_CAUSE_HI_I, // Alert came from upper limit
  output logic ALERT_O, // Alert output, active high
  output logic ALERT_BEHAVIOUR_SELECT_O, // 1: interrupt behaviour
  output logic [7:0] CONFIG_O, // Configuration register
  output logic [15:0] TLOW_O, // Lower limit register
  output logic [15:0] THIGH_O, // Upper limit register
  output logic HS_MODE_O, // High-speed filters selected
  output logic [6:0] SLAVE_ADDR_O // Latched slave address
);
  logic [6:0] pin_s;
  logic scl, sda, rst_l, tgl_s;
  logic [2:0] apin;
  logic scl_q_r, sda_q_r, tgl_q_r;
  logic start_e, stop_e, rise_e, fall_e, tmo_e, byte_done;
  logic tmo_tgl;
  state_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic sda_oe_r, mack_r, first_r;
  logic rw_r, gc_r, ara_r, lo_r;
  logic [1:0] bidx_r, ptr_r;
  logic [7:0] cfg_r;
  logic [15:0] tlow_r, thigh_r, tx_w_r;
  logic [7:0] tx_byte;
  logic alert_r, cause_r, hs_r, busy_r, low_r;
  logic [6:0] addr_r;
  logic mode, me_hit, gc_hit, ara_hit, hs_hit, acc;
  logic addr_done, rd_ack, hs_enter, rx_byte, tx_end;
  logic wr_ptr, wr_hi, wr_lo, gc_cmd, gc_rst, gc_latch;
  logic ara_won, ara_lost;

  // Pins, reset and the expiry toggle all enter the link domain here
  sync2 #(.W(7)) u_pin_sync (
    .clk_i(LINK_CLK_I),
    .d_i({SCL_I, SDA_I, ADDR_SELECT_PIN_2_I, ADDR_SELECT_PIN_1_I,
          ADDR_SELECT_PIN_0_I, SRST_I, tmo_tgl}),
    .q_o(pin_s)
  );

  bus_timeout #(.LIMIT_P(TIMEOUT_CYC_P)) u_timeout (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .low_i(low_r),
    .tmo_tgl_o(tmo_tgl)
  );

  assign scl = pin_s[6];
  assign sda = pin_s[5];
  assign apin = pin_s[4:2];
  assign rst_l = pin_s[1];
  assign tgl_s = pin_s[0];

  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end

  // Unconditional so that no false expiry appears after reset
  always_ff @(posedge LINK_CLK_I) begin
    tgl_q_r <= tgl_s;
  end

  assign start_e = scl & scl_q_r & sda_q_r & ~sda;
  assign stop_e = scl & scl_q_r & ~sda_q_r & sda;
  assign rise_e = scl & ~scl_q_r;
  assign fall_e = ~scl & scl_q_r;
  assign tmo_e = tgl_s ^ tgl_q_r;
  assign byte_done = fall_e && cnt_r == BIT_LAST;

  assign mode = cfg_r[CFG_MODE_BIT];
  assign me_hit = sh_r[7:1] == addr_r;
  assign gc_hit = sh_r == GC_ADDR;
  assign ara_hit = sh_r == ARA_ADDR && alert_r && mode;
  assign hs_hit = first_r && sh_r[7:3] == HS_CODE;
  assign acc = me_hit || gc_hit || ara_hit;

  assign addr_done = st_r == ST_ADDR && byte_done;
  assign rd_ack = addr_done && me_hit && sh_r[0];
  assign hs_enter = addr_done && hs_hit;
  assign rx_byte = st_r == ST_RX && byte_done;
  assign tx_end = st_r == ST_TX && byte_done;
  assign wr_ptr = rx_byte && !gc_r && bidx_r == BIDX_PTR;
  assign wr_hi = rx_byte && !gc_r && bidx_r == BIDX_HI;
  assign wr_lo = rx_byte && !gc_r && bidx_r == BIDX_LO &&
                 (ptr_r == PTR_TLOW || ptr_r == PTR_THIGH);
  assign gc_cmd = rx_byte && gc_r && bidx_r == BIDX_PTR;
  assign gc_rst = gc_cmd && sh_r == GC_CMD_RESET;
  assign gc_latch = gc_cmd && (sh_r == GC_CMD_LATCH || gc_rst);
  assign ara_won = st_r == ST_MACK && rise_e && ara_r;
  assign ara_lost = st_r == ST_TX && rise_e && ara_r && !sda_oe_r &&
                    !sda;

  // Alert response returns own address plus cause; else register bytes
  assign tx_byte = ara_r ? {addr_r, cause_r} :
                   (lo_r ? tx_w_r[7:0] : tx_w_r[15:8]);

  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l || tmo_e || stop_e) begin
      st_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
      cnt_r <= '0;
      sh_r <= '0;
      mack_r <= 1'b0;
    end else if (start_e) begin
      st_r <= ST_ADDR;
      sda_oe_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
        end
        ST_ADDR, ST_RX: begin
          if (rise_e) begin
            sh_r <= {sh_r[6:0], sda};
            cnt_r <= cnt_r + 4'h1;
          end
          if (byte_done) begin
            cnt_r <= '0;
            if (st_r == ST_RX || acc) begin
              sda_oe_r <= 1'b1;
              st_r <= ST_ACK;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (fall_e) begin
            cnt_r <= '0;
            if (rw_r) begin
              sh_r <= tx_byte;
              sda_oe_r <= ~tx_byte[7];
              st_r <= ST_TX;
            end else begin
              sda_oe_r <= 1'b0;
              st_r <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (rise_e) begin
            cnt_r <= cnt_r + 4'h1;
          end
          if (ara_lost) begin
            sda_oe_r <= 1'b0;
            st_r <= ST_IDLE;
          end else if (byte_done) begin
            sda_oe_r <= 1'b0;
            cnt_r <= '0;
            st_r <= ST_MACK;
          end else if (fall_e) begin
            sh_r <= {sh_r[6:0], 1'b0};
            sda_oe_r <= ~sh_r[6];
          end
        end
        ST_MACK: begin
          if (rise_e) begin
            mack_r <= ~sda;
          end
          if (fall_e) begin
            if (mack_r && !ara_r) begin
              sh_r <= tx_byte;
              sda_oe_r <= ~tx_byte[7];
              st_r <= ST_TX;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Transfer attributes fixed when the address byte completes
  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l) begin
      rw_r <= 1'b0;
      gc_r <= 1'b0;
      ara_r <= 1'b0;
    end else if (addr_done) begin
      rw_r <= sh_r[0];
      gc_r <= gc_hit;
      ara_r <= ara_hit && !me_hit;
    end
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l || start_e) begin
      first_r <= 1'b0;
    end else if (addr_done) begin
      first_r <= 1'b0;
    end
    if (start_e) begin
      first_r <= 1'b1;
    end
  end

  // Saturates, so any number of bytes is acknowledged
  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l || addr_done) begin
      bidx_r <= BIDX_PTR;
    end else if (rx_byte && bidx_r != BIDX_MAX) begin
      bidx_r <= bidx_r + 2'h1;
    end
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l || addr_done) begin
      lo_r <= 1'b0;
    end else if (tx_end) begin
      lo_r <= ~lo_r;
    end
  end

  // Whole word captured at the address so both bytes are coherent
  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l) begin
      tx_w_r <= '0;
    end else if (rd_ack) begin
      unique case (ptr_r)
        PTR_TEMP: tx_w_r <= TEMP_I;
        PTR_CFG: tx_w_r <= {cfg_r, cfg_r};
        PTR_TLOW: tx_w_r <= tlow_r;
        PTR_THIGH: tx_w_r <= thigh_r;
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l || gc_rst) begin
      ptr_r <= PTR_RST;
      cfg_r <= CFG_RST;
      tlow_r <= TLOW_RST;
      thigh_r <= THIGH_RST;
    end else begin
      if (wr_ptr) begin
        ptr_r <= sh_r[1:0];
      end
      if (wr_hi) begin
        unique case (ptr_r)
          PTR_TEMP: begin
          end
          PTR_CFG: cfg_r <= sh_r;
          PTR_TLOW: tlow_r[15:8] <= sh_r;
          PTR_THIGH: thigh_r[15:8] <= sh_r;
        endcase
      end
      if (wr_lo && ptr_r == PTR_TLOW) begin
        tlow_r[7:0] <= sh_r;
      end
      if (wr_lo && ptr_r == PTR_THIGH) begin
        thigh_r[7:0] <= sh_r;
      end
    end
  end

  // In interrupt behaviour a new request in the same cycle as a clear wins; in comparator behaviour a general call reset wins
  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l) begin
      alert_r <= 1'b0;
      cause_r <= 1'b0;
    end else if (mode && ALERT_SET_I) begin
      alert_r <= 1'b1;
      cause_r <= ALERT_CAUSE_HI_I;
    end else if (gc_rst || (mode && (rd_ack || ara_won))) begin
      alert_r <= 1'b0;
    end else if (!mode) begin
      alert_r <= ALERT_SET_I;
      cause_r <= ALERT_CAUSE_HI_I;
    end
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l || stop_e || tmo_e) begin
      hs_r <= 1'b0;
    end else if (hs_enter) begin
      hs_r <= 1'b1;
    end
  end

  // Straps re-read whenever reset is held, at START and on command
  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l || start_e || gc_latch) begin
      addr_r <= {ADDR_HI, apin};
    end
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l || stop_e || tmo_e) begin
      busy_r <= 1'b0;
    end else if (start_e) begin
      busy_r <= 1'b1;
    end
  end

  // Registered so the crossing sees no decode glitches
  always_ff @(posedge LINK_CLK_I) begin
    if (rst_l) begin
      low_r <= 1'b0;
    end else begin
      low_r <= busy_r && (!scl || !sda);
    end
  end

  assign SCL_O = 1'b0;
  assign SCL_OE_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe_r;
  assign ALERT_O = alert_r;
  assign ALERT_BEHAVIOUR_SELECT_O = mode;
  assign CONFIG_O = cfg_r;
  assign TLOW_O = tlow_r;
  assign THIGH_O = thigh_r;
  assign HS_MODE_O = hs_r;
  assign SLAVE_ADDR_O = addr_r;

  default clocking cb @(posedge LINK_CLK_I); endclocking
  default disable iff (rst_l);

  AST_PTR_ONLY_BY_WRITE: assert property (
    $changed(ptr_r) |-> $past(wr_ptr) || $past(gc_rst))
    else $error("pointer changed without a pointer write");
  AST_MSB_FIRST: assert property (
    (st_r == ST_ACK && fall_e && rw_r && !tmo_e && !ara_r) |=>
      sda_oe_r == !$past(tx_w_r[15]) && sh_r == $past(tx_w_r[15:8]))
    else $error("transmit byte not started with its MSB");
  AST_ARA_NEEDS_MODE: assert property (
    (addr_done && sh_r == ARA_ADDR && !mode && !tmo_e) |=> !sda_oe_r)
    else $error("alert response acknowledged in comparator behaviour");
  AST_ARA_LOSE_KEEPS: assert property (
    ara_lost |=> alert_r ##1 alert_r)
    else $error("alert dropped after lost arbitration");
  AST_GC_RESET: assert property (
    gc_rst |=> cfg_r == CFG_RST && tlow_r == TLOW_RST &&
      thigh_r == THIGH_RST && ptr_r == PTR_RST)
    else $error("general call reset did not restore registers");
  AST_UNMATCHED_NACK: assert property (
    (addr_done && !acc && !tmo_e) |=> !sda_oe_r && st_r == ST_IDLE)
    else $error("unmatched address acknowledged");
  AST_HS_NO_ACK: assert property (
    (hs_enter && !tmo_e) |=> hs_r && !sda_oe_r)
    else $error("high-speed code mishandled");
  AST_HS_STOP_EXIT: assert property (
    stop_e |=> !hs_r)
    else $error("high-speed mode kept after STOP");
  AST_TMO_RELEASE: assert property (
    tmo_e |=> st_r == ST_IDLE && !sda_oe_r && !busy_r)
    else $error("timeout did not release the bus");
  AST_ACK_STABLE: assert property (
    (st_r == ST_ACK && scl && scl_q_r) |-> sda_oe_r)
    else $error("acknowledge not held through clock high");
  AST_READ_CLEARS: assert property (
    (rd_ack && mode && !ALERT_SET_I) |=> !alert_r)
    else $error("register read did not clear the alert");

  COV_WRITE_DATA: cover property (wr_hi ##[1:1000] wr_lo);
  COV_READ_TWO: cover property (rd_ack ##[1:1000] tx_end ##[1:1000] tx_end);
  COV_ARA_WON: cover property (ara_won);
  COV_HS_ENTRY: cover property (hs_enter);
endmodule

// ==== tws_slave_tb.sv ====
// Self-checking bench for the two-wire sensor slave port
module tws_slave_tb import tws_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] pins = 3'b000;
  logic [15:0] temp = 16'h1a2b;
  logic al_set = 1'b0;
  logic al_hi = 1'b0;
  logic scl_m, sda_m, scl_d, scl_oe, sda_d, sda_oe;
  logic alert, mode, hs, nak;
  logic [7:0] cfg, d;
  logic [15:0] tlow, thigh;
  logic [6:0] saddr;
  int num_errors = 0;
  int total_checks = 0;
  wire scl = scl_m & ~(scl_oe & ~scl_d);
  wire sda = sda_m & ~(sda_oe & ~sda_d);
  wire [6:0] me = {ADDR_HI, pins};
  always #5 clk = ~clk;
  always #7.5 link_clk = ~link_clk;
  // Short timeout keeps the run brief, still far above any bit run
  tws_slave #(.TIMEOUT_CYC_P(2000)) uut (
    .CLK_I(clk), .SRST_I(srst), .LINK_CLK_I(link_clk), .SCL_I(scl),
    .SCL_O(scl_d), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_d),
    .SDA_OE_O(sda_oe), .ADDR_SELECT_PIN_0_I(pins[0]),
    .ADDR_SELECT_PIN_1_I(pins[1]), .ADDR_SELECT_PIN_2_I(pins[2]),
    .TEMP_I(temp), .ALERT_SET_I(al_set), .ALERT_CAUSE_HI_I(al_hi),
    .ALERT_O(alert), .ALERT_BEHAVIOUR_SELECT_O(mode), .CONFIG_O(cfg),
    .TLOW_O(tlow), .THIGH_O(thigh), .HS_MODE_O(hs),
    .SLAVE_ADDR_O(saddr));
  tws_master_model m (.clk_i(clk), .sda_i(sda), .scl_o(scl_m),
    .sda_o(sda_m));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Frame left open so the caller ends it by STOP or repeated START
  task automatic wr(input logic [1:0] ptr, input int n,
                    input logic [23:0] v);
    m.start();
    m.wbyte({me, 1'b0}, nak);
    chk(nak, 0);
    m.wbyte({6'h00, ptr}, nak);
    chk(nak, 0);
    for (int k = n - 1; k >= 0; k--) begin
      m.wbyte(v[8*k +: 8], nak);
      chk(nak, 0);
    end
  endtask
  task automatic rd(input int n, input logic [31:0] exp);
    m.start();
    m.wbyte({me, 1'b1}, nak);
    chk(nak, 0);
    for (int k = n - 1; k >= 0; k--) begin
      m.rbyte(8'hff, k > 0, d);
      chk(d, exp[8*k +: 8]);
    end
    chk(sda_oe, 0);
    m.stop();
  endtask
  task automatic pulse(input logic hi);
    al_hi = hi;
    al_set = 1'b1;
    step(5);
    al_set = 1'b0;
    step(5);
  endtask
  task automatic ara(input logic [7:0] drv, input logic [7:0] exp);
    m.start();
    m.wbyte(ARA_ADDR, nak);
    chk(nak, 0);
    m.rbyte(drv, 1'b0, d);
    chk(d, exp);
    m.stop();
  endtask
  task automatic gc(input logic [7:0] cmd, input logic [2:0] p);
    m.start();
    m.wbyte(GC_ADDR, nak);
    chk(nak, 0);
    // Straps move after the address, so only the command can latch them
    pins = p;
    m.wbyte(cmd, nak);
    chk(nak, 0);
    m.stop();
    step(5);
  endtask
  task automatic t_reset();
    chk(cfg, CFG_RST);
    chk(tlow, TLOW_RST);
    chk(thigh, THIGH_RST);
    chk(alert, 0);
    chk(hs, 0);
    chk(sda_oe, 0);
    chk(scl_oe, 0);
    chk(scl_d, 0);
    chk(sda_d, 0);
    chk(saddr, me);
    $display("test reset done");
  endtask
  task automatic t_write();
    wr(PTR_TLOW, 2, 24'h00_1234);
    m.stop();
    chk(tlow, 16'h1234);
    wr(PTR_THIGH, 3, 24'hab_cdef);
    m.stop();
    chk(thigh, 16'habcd);
    wr(PTR_TLOW, 1, 24'h00_0077);
    m.stop();
    chk(tlow, 16'h7734);
    $display("test write done");
  endtask
  task automatic t_read();
    wr(PTR_THIGH, 0, 24'h00_0000);
    rd(4, 32'habcd_abcd);
    rd(2, 32'h0000_abcd);
    wr(PTR_TEMP, 2, 24'h00_5555);
    rd(2, {16'h0000, temp});
    $display("test read done");
  endtask
  task automatic t_nomatch();
    m.start();
    m.wbyte({ADDR_HI, ~pins, 1'b0}, nak);
    chk(nak, 1);
    chk(sda_oe, 0);
    m.stop();
    m.start();
    m.wbyte(ARA_ADDR, nak);
    chk(nak, 1);
    m.stop();
    $display("test unmatched done");
  endtask
  task automatic t_alert();
    wr(PTR_CFG, 1, 24'h00_0002);
    m.stop();
    chk(mode, 1);
    pulse(1'b1);
    chk(alert, 1);
    ara(8'hff, {me, 1'b1});
    chk(alert, 0);
    pulse(1'b0);
    ara(8'hff, {me, 1'b0});
    chk(alert, 0);
    pulse(1'b1);
    ara(8'h00, 8'h00);
    chk(alert, 1);
    rd(2, 32'h0000_0202);
    chk(alert, 0);
    $display("test alert done");
  endtask
  task automatic t_gcall();
    gc(GC_CMD_LATCH, 3'b101);
    chk(saddr, {ADDR_HI, 3'b101});
    chk(thigh, 16'habcd);
    chk(mode, 1);
    pulse(1'b1);
    gc(GC_CMD_RESET, 3'b101);
    chk(thigh, THIGH_RST);
    chk(tlow, TLOW_RST);
    chk(cfg, CFG_RST);
    chk(alert, 0);
    chk(mode, 0);
    $display("test general call done");
  endtask
  task automatic t_hs_tmo();
    m.start();
    m.wbyte({HS_CODE, 3'b011}, nak);
    chk(nak, 1);
    chk(hs, 1);
    wr(PTR_TLOW, 0, 24'h00_0000);
    chk(hs, 1);
    m.stop();
    chk(hs, 0);
    m.start();
    m.wbyte({HS_CODE, 3'b000}, nak);
    m.start();
    d = {me, 1'b0};
    for (int i = 7; i >= 0; i--) begin
      m.bit_io(d[i], nak);
    end
    chk(sda_oe, 1);
    // SCL now held low past the limit while the slave pulls data low
    step(2500);
    chk(sda_oe, 0);
    chk(hs, 0);
    m.stop();
    $display("test speed and timeout done");
  endtask
  initial begin
    step(4);
    srst = 1'b0;
    step(10);
    t_reset();
    t_write();
    t_read();
    t_nomatch();
    t_alert();
    t_gcall();
    t_hs_tmo();
    summarize();
  end
  initial begin
    #1_000_000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
